/* inc/srf_frm_if.sv */
// Link between the frame sequencer and the frame byte generator
`timescale 1ns/1ps
`default_nettype none
interface srf_frm_if;
   import srf_pkg::*;
   logic [4:0]  idx;
   srf_sample_t samp;
   logic [7:0]  byte_val;
   modport seq (output idx, output samp, input byte_val);
   modport gen (input idx, input samp, output byte_val);
endinterface
`default_nettype wire

/* inc/srf_pkg.sv */
// Constants and types shared by the sensor read frame builder
`default_nettype none
package srf_pkg;
   // Frame framing
   localparam logic [7:0]  SRF_START      = 8'h7e;
   localparam logic [7:0]  SRF_TYPE       = 8'h94;
   localparam logic [15:0] SRF_LEN        = 16'h0017;
   localparam logic [7:0]  SRF_CKS_BASE   = 8'hff;
   localparam int          SRF_PAY_BYTES  = 23;
   localparam int          SRF_PAY_W      = 184;
   // Byte positions within the frame
   localparam logic [4:0]  SRF_OFF_START  = 5'h00;
   localparam logic [4:0]  SRF_OFF_LEN_HI = 5'h01;
   localparam logic [4:0]  SRF_OFF_LEN_LO = 5'h02;
   localparam logic [4:0]  SRF_OFF_TYPE   = 5'h03;
   localparam logic [4:0]  SRF_OFF_A64_HI = 5'h04;
   localparam logic [4:0]  SRF_OFF_A64_LO = 5'h0b;
   localparam logic [4:0]  SRF_OFF_A16_HI = 5'h0c;
   localparam logic [4:0]  SRF_OFF_A16_LO = 5'h0d;
   localparam logic [4:0]  SRF_OFF_OPT    = 5'h0e;
   localparam logic [4:0]  SRF_OFF_SENS   = 5'h0f;
   localparam logic [4:0]  SRF_OFF_AD_HI  = 5'h10;
   localparam logic [4:0]  SRF_OFF_AD_LO  = 5'h17;
   localparam logic [4:0]  SRF_OFF_T_HI   = 5'h18;
   localparam logic [4:0]  SRF_OFF_T_LO   = 5'h19;
   localparam logic [4:0]  SRF_OFF_CKS    = 5'h1a;
   // Receive option and sensor flags
   localparam logic [7:0]  SRF_RX_ACK     = 8'h01;
   localparam logic [7:0]  SRF_RX_BCAST   = 8'h02;
   localparam logic [7:0]  SRF_RX_ENC     = 8'h20;
   localparam logic [7:0]  SRF_SN_AD      = 8'h01;
   localparam logic [7:0]  SRF_SN_TEMP    = 8'h02;
   localparam logic [7:0]  SRF_SN_WATER   = 8'h60;
   localparam logic [7:0]  SRF_OPT_STD    = 8'h00;
   // Register map
   localparam logic [7:0]  SRF_REG_CTRL   = 8'h00;
   localparam logic [7:0]  SRF_REG_STAT   = 8'h04;
   localparam logic [7:0]  SRF_CTRL_RST   = 8'h00;

   typedef enum logic {SRF_IDLE, SRF_SEND} srf_state_t;

   typedef struct packed {
      logic [63:0] src64;
      logic [15:0] src16;
      logic [7:0]  rxopt;
      logic [7:0]  sens;
      logic [63:0] ad;
      logic [15:0] temp;
   } srf_sample_t;
endpackage
`default_nettype wire

/* rtl/srf_byte_gen.sv */
// Frame byte generator: returns the frame byte at a given index
`timescale 1ns/1ps
`default_nettype none
module srf_byte_gen
   import srf_pkg::*;
(
   // Sequencer side
   srf_frm_if.gen f
);
   logic [SRF_PAY_W-1:0] pay;
   logic [7:0]           pb [SRF_PAY_BYTES];
   logic [7:0]           sum;

   // Type through temperature, most significant byte first
   assign pay = {SRF_TYPE, f.samp.src64, f.samp.src16, f.samp.rxopt,
                 f.samp.sens, f.samp.ad, f.samp.temp};

   genvar i;
   generate
      for (i = 0; i < SRF_PAY_BYTES; i++) begin : g_pb
         assign pb[i] = pay[SRF_PAY_W-1-8*i -: 8];
      end
   endgenerate

   always_comb begin
      sum = 8'h00;
      for (int k = 0; k < SRF_PAY_BYTES; k++) begin
         sum = sum + pb[k];
      end
   end

   always_comb begin
      if (f.idx == SRF_OFF_START) begin
         f.byte_val = SRF_START;
      end else if (f.idx == SRF_OFF_LEN_HI) begin
         f.byte_val = SRF_LEN[15:8];
      end else if (f.idx == SRF_OFF_LEN_LO) begin
         f.byte_val = SRF_LEN[7:0];
      end else if (f.idx == SRF_OFF_CKS) begin
         f.byte_val = SRF_CKS_BASE - sum;
      end else if (f.idx > SRF_OFF_CKS) begin
         f.byte_val = 8'h00;
      end else begin
         f.byte_val = pb[5'(f.idx - SRF_OFF_TYPE)];
      end
   end
endmodule
`default_nettype wire

/* rtl/srf_frame_builder.sv */
// Sensor read frame builder with a classic Wishbone control port
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Standard output option emits type byte 0x94
// - 64-bit source address, bytes 4-11, MSB first
// - 16-bit network address, bytes 12-13, MSB first
// - Receive options: ack, broadcast, encrypted flags
// - Sensor byte: analog, temperature, water flags
// - Four analog readings; all ones if absent
// - Temperature reading; 0xFFFF if absent
// - Checksum is 0xFF minus payload sum
// - Length counts bytes between length and checksum
module srf_frame_builder
   import srf_pkg::*;
#(
   parameter int ADR_W = 8
)(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             srst,
   // Wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // Incoming sensor sample
   input  wire logic             sample_valid,
   output logic                  sample_ready,
   input  wire logic [63:0]      src64_addr,
   input  wire logic [15:0]      src16_addr,
   input  wire logic             rx_acked,
   input  wire logic             rx_broadcast,
   input  wire logic             rx_encrypted,
   input  wire logic             ad_found,
   input  wire logic [63:0]      ad_values,
   input  wire logic             temp_found,
   input  wire logic [15:0]      temp_value,
   input  wire logic             water_detect_pin,
   // Serial frame byte stream
   output logic                  tx_valid,
   output logic      [7:0]       tx_data,
   input  wire logic             tx_ready
);
   typedef struct packed {
      srf_state_t  st;
      logic [4:0]  nxt;
      logic [4:0]  pos;
      logic        tx_valid;
      logic [7:0]  tx_data;
      logic        rdy;
      srf_sample_t samp;
      logic [7:0]  api_output_option;
      logic [15:0] frames;
      logic [7:0]  skipped;
      logic        ack;
      logic [31:0] rdata;
      logic [7:0]  acc;
   } srf_regs_t;

   srf_regs_t q;
   srf_regs_t next_q;
   srf_frm_if fi ();

   logic        req;
   logic        take;
   logic        adv;
   logic [31:0] stat_word;
   srf_sample_t cap;

   srf_byte_gen u_gen (
      .f (fi.gen)
   );

   assign fi.idx  = q.nxt;
   assign fi.samp = q.samp;

   assign req  = wb_cyc_i && wb_stb_i && !q.ack;
   assign take = sample_valid && q.rdy;
   assign adv  = !q.tx_valid || tx_ready;
   assign stat_word = {q.frames, q.skipped, 7'h00,
                       (q.st == SRF_SEND)};

   // Sample fields as they will appear in the frame
   always_comb begin
      cap.src64 = src64_addr;
      cap.src16 = src16_addr;
      cap.rxopt = (rx_acked     ? SRF_RX_ACK   : 8'h00)
                | (rx_broadcast ? SRF_RX_BCAST : 8'h00)
                | (rx_encrypted ? SRF_RX_ENC   : 8'h00);
      cap.sens  = (ad_found          ? SRF_SN_AD    : 8'h00)
                | (temp_found        ? SRF_SN_TEMP  : 8'h00)
                | (!water_detect_pin ? SRF_SN_WATER : 8'h00);
      cap.ad    = ad_found ? ad_values : {8{8'hff}};
      cap.temp  = temp_found ? temp_value : 16'hffff;
   end

   always_comb begin
      next_q     = q;
      next_q.ack = wb_cyc_i && wb_stb_i && !q.ack;
      // Write lands on the edge at which the master sees ack
      if (wb_cyc_i && wb_stb_i && q.ack && wb_we_i &&
          wb_adr_i == ADR_W'(SRF_REG_CTRL) && wb_sel_i[0]) begin
         next_q.api_output_option = wb_dat_i[7:0];
      end
      if (req) begin
         if (wb_adr_i == ADR_W'(SRF_REG_CTRL)) begin
            next_q.rdata = {24'h000000, q.api_output_option};
         end else if (wb_adr_i == ADR_W'(SRF_REG_STAT)) begin
            next_q.rdata = stat_word;
         end else begin
            next_q.rdata = 32'h00000000;
         end
      end
      unique case (q.st)
         SRF_IDLE: begin
            if (take) begin
               if (q.api_output_option == SRF_OPT_STD) begin
                  next_q.st   = SRF_SEND;
                  next_q.samp = cap;
                  next_q.nxt  = SRF_OFF_START;
                  next_q.acc  = 8'h00;
                  next_q.rdy  = 1'b0;
               end else begin
                  next_q.skipped = q.skipped + 8'h01;
               end
            end
         end
         SRF_SEND: begin
            if (q.tx_valid && tx_ready && q.pos >= SRF_OFF_TYPE &&
                q.pos < SRF_OFF_CKS) begin
               next_q.acc = q.acc + q.tx_data;
            end
            if (adv) begin
               if (q.tx_valid && q.pos == SRF_OFF_CKS) begin
                  next_q.st       = SRF_IDLE;
                  next_q.tx_valid = 1'b0;
                  next_q.rdy      = 1'b1;
                  next_q.frames   = q.frames + 16'h0001;
               end else begin
                  next_q.tx_data  = fi.byte_val;
                  next_q.tx_valid = 1'b1;
                  next_q.pos      = q.nxt;
                  next_q.nxt      = q.nxt + 5'h01;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         q                   <= '0;
         q.st                <= SRF_IDLE;
         q.rdy               <= 1'b1;
         q.api_output_option <= SRF_CTRL_RST;
      end else begin
         q <= next_q;
      end
   end

   assign wb_dat_o     = q.rdata;
   assign wb_ack_o     = q.ack;
   assign sample_ready = q.rdy;
   assign tx_valid     = q.tx_valid;
   assign tx_data      = q.tx_data;

   property p_type_byte;
      @(posedge clk_sys) disable iff (srst)
      q.tx_valid && q.pos == SRF_OFF_TYPE |-> q.tx_data == SRF_TYPE;
   endproperty
   a_type_byte: assert property (p_type_byte)
      else $error("frame type byte wrong");

   property p_opt_gate;
      @(posedge clk_sys) disable iff (srst)
      take && q.api_output_option != SRF_OPT_STD |=> ##1 !q.tx_valid;
   endproperty
   a_opt_gate: assert property (p_opt_gate)
      else $error("frame sent with non-standard output option");

   property p_addr64;
      @(posedge clk_sys) disable iff (srst)
      q.tx_valid && q.pos == SRF_OFF_A64_HI |->
         q.tx_data == q.samp.src64[63:56];
   endproperty
   a_addr64: assert property (p_addr64)
      else $error("64-bit address not msb first");

   property p_addr64_lo;
      @(posedge clk_sys) disable iff (srst)
      q.tx_valid && q.pos == SRF_OFF_A64_LO |->
         q.tx_data == q.samp.src64[7:0];
   endproperty
   a_addr64_lo: assert property (p_addr64_lo)
      else $error("64-bit address lsb misplaced");

   property p_addr16;
      @(posedge clk_sys) disable iff (srst)
      q.tx_valid && tx_ready && q.pos == SRF_OFF_A16_HI |=>
         q.tx_valid && q.pos == SRF_OFF_A16_LO &&
         q.tx_data == q.samp.src16[7:0];
   endproperty
   a_addr16: assert property (p_addr16)
      else $error("16-bit address order wrong");

   property p_rxopt;
      @(posedge clk_sys) disable iff (srst)
      q.tx_valid && q.pos == SRF_OFF_OPT |->
         (q.tx_data & ~(SRF_RX_ACK | SRF_RX_BCAST | SRF_RX_ENC)) == 8'h00;
   endproperty
   a_rxopt: assert property (p_rxopt)
      else $error("receive options hold unknown flags");

   property p_sens;
      @(posedge clk_sys) disable iff (srst)
      take && q.api_output_option == SRF_OPT_STD && !water_detect_pin |=>
         (q.samp.sens & SRF_SN_WATER) == SRF_SN_WATER;
   endproperty
   a_sens: assert property (p_sens)
      else $error("water flag missing");

   property p_ad_absent;
      @(posedge clk_sys) disable iff (srst)
      q.tx_valid && q.pos >= SRF_OFF_AD_HI && q.pos <= SRF_OFF_AD_LO &&
         (q.samp.sens & SRF_SN_AD) == 8'h00 |-> q.tx_data == 8'hff;
   endproperty
   a_ad_absent: assert property (p_ad_absent)
      else $error("absent analog field not all ones");

   property p_temp_absent;
      @(posedge clk_sys) disable iff (srst)
      q.tx_valid && (q.pos == SRF_OFF_T_HI || q.pos == SRF_OFF_T_LO) &&
         (q.samp.sens & SRF_SN_TEMP) == 8'h00 |-> q.tx_data == 8'hff;
   endproperty
   a_temp_absent: assert property (p_temp_absent)
      else $error("absent temperature not 0xffff");

   property p_checksum;
      @(posedge clk_sys) disable iff (srst)
      q.tx_valid && q.pos == SRF_OFF_CKS |->
         8'(q.tx_data + q.acc) == SRF_CKS_BASE;
   endproperty
   a_checksum: assert property (p_checksum)
      else $error("checksum mismatch");

   property p_length;
      @(posedge clk_sys) disable iff (srst)
      // Only on the first cycle of the low byte, so a stall does not confuse it
      q.tx_valid && q.pos == SRF_OFF_LEN_LO && $past(q.pos) == SRF_OFF_LEN_HI |->
         q.tx_data == SRF_LEN[7:0] && $past(q.tx_data) == SRF_LEN[15:8];
   endproperty
   a_length: assert property (p_length)
      else $error("length field wrong");

   property p_ad_order;
      @(posedge clk_sys) disable iff (srst)
      q.tx_valid && q.pos == SRF_OFF_AD_HI |->
         q.tx_data == q.samp.ad[63:56];
   endproperty
   a_ad_order: assert property (p_ad_order)
      else $error("analog reading A not msb first");

   property p_hold;
      @(posedge clk_sys) disable iff (srst)
      q.tx_valid && !tx_ready |=> q.tx_valid && $stable(q.tx_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("byte changed while stalled");

   property p_start;
      @(posedge clk_sys) disable iff (srst)
      $rose(q.tx_valid) |->
         q.pos == SRF_OFF_START && q.tx_data == SRF_START;
   endproperty
   a_start: assert property (p_start)
      else $error("frame does not open with the start delimiter");

   property p_ad_last;
      @(posedge clk_sys) disable iff (srst)
      q.tx_valid && q.pos == SRF_OFF_AD_LO |->
         q.tx_data == q.samp.ad[7:0];
   endproperty
   a_ad_last: assert property (p_ad_last)
      else $error("analog reading D low byte misplaced");

   property p_temp_order;
      @(posedge clk_sys) disable iff (srst)
      q.tx_valid && q.pos == SRF_OFF_T_HI |->
         q.tx_data == q.samp.temp[15:8];
   endproperty
   a_temp_order: assert property (p_temp_order)
      else $error("temperature not msb first");

   property p_frame_end;
      @(posedge clk_sys) disable iff (srst)
      q.tx_valid && tx_ready && q.pos == SRF_OFF_CKS |=>
         !q.tx_valid && q.rdy && q.st == SRF_IDLE;
   endproperty
   a_frame_end: assert property (p_frame_end)
      else $error("frame does not end after the checksum byte");
endmodule
`default_nettype wire

/* verification/srf_host_model.sv */
// Host side model: takes frame bytes, may stall, checks the checksum
`timescale 1ns/1ps
`default_nettype none
module srf_host_model (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       srst,
   // Pacing control
   input  wire logic       slow,
   // Byte stream
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output var  logic       tx_ready,
   // Captured frame
   output var  logic [7:0] frm [0:26],
   output var  int         nfrm,
   output var  logic       cks_ok
);
   int         idx;
   logic [7:0] sum;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tx_ready <= 1'b0;
         idx      <= 0;
         sum      <= 8'h00;
         nfrm     <= 0;
         cks_ok   <= 1'b0;
      end else begin
         // A slow host answers only every other cycle
         tx_ready <= slow ? ~tx_ready : 1'b1;
         if (tx_valid && tx_ready) begin
            frm[idx] <= tx_data;
            if (idx >= 3) sum <= sum + tx_data;
            if (idx == 26) begin
               cks_ok <= (8'(sum + tx_data) == 8'hff);
               nfrm   <= nfrm + 1;
               idx    <= 0;
               sum    <= 8'h00;
            end else begin
               idx <= idx + 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the sensor read frame builder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import srf_pkg::*;
   logic        clk_sys = 1'b0, srst = 1'b1, slow = 1'b0;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic        sample_valid = 1'b0, sample_ready, rx_acked = 1'b0, rx_broadcast = 1'b0;
   logic        rx_encrypted = 1'b0, ad_found = 1'b0, temp_found = 1'b0, water_detect_pin = 1'b1;
   logic [63:0] src64_addr = 64'h0, ad_values = 64'h0;
   logic [15:0] src16_addr = 16'h0, temp_value = 16'h0;
   logic        tx_valid, tx_ready, cks_ok;
   logic [7:0]  tx_data, ex [0:26], frm [0:26];
   int          nfrm, err_total = 0, checked = 0, cyc_cnt = 0;

   always #4 clk_sys = ~clk_sys;

   srf_frame_builder #(.ADR_W(8)) dut (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .src64_addr(src64_addr), .src16_addr(src16_addr),
      .rx_acked(rx_acked), .rx_broadcast(rx_broadcast), .rx_encrypted(rx_encrypted),
      .ad_found(ad_found), .ad_values(ad_values), .temp_found(temp_found), .temp_value(temp_value),
      .water_detect_pin(water_detect_pin), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

   srf_host_model host (.clk_sys(clk_sys), .srst(srst), .slow(slow), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .frm(frm), .nfrm(nfrm), .cks_ok(cks_ok));

   task automatic close_out();
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Hang guard at 20000 cycles; the whole run needs well under 2000
   always @(posedge clk_sys) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         err_total++;
         $display("BAD %0t timeout", $time);
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Classic single Wishbone cycle, held until ack is seen
   task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic offer();
      @(posedge clk_sys);
      sample_valid <= 1'b1;
      do @(posedge clk_sys); while (sample_ready !== 1'b1);
      sample_valid <= 1'b0;
   endtask

   // Sends one sample and compares the whole frame the host received
   task automatic run_frame(input logic [2:0] rx, input logic adf, input logic tpf,
                            input logic wat, input logic slw, input logic [7:0] k);
      int          n0, i;
      logic [63:0] v64, vad;
      logic [15:0] v16, vt;
      logic [7:0]  s;
      v64 = 64'h0123456789abcdef ^ {8{k}};
      vad = 64'h0002_00ce_00ea_0052 + {8{k}};
      v16 = 16'hdd6c ^ {2{k}};
      vt  = 16'h016a + {8'h00, k};
      src64_addr <= v64;
      src16_addr <= v16;
      {rx_encrypted, rx_broadcast, rx_acked} <= rx;
      ad_found <= adf;
      ad_values <= vad;
      temp_found <= tpf;
      temp_value <= vt;
      water_detect_pin <= wat;
      slow <= slw;
      ex[0] = SRF_START;
      {ex[1], ex[2]} = SRF_LEN;
      ex[3] = 8'h94;
      for (i = 0; i < 8; i++) ex[4+i] = v64[63-8*i -: 8];
      {ex[12], ex[13]} = v16;
      ex[14] = (rx[0] ? 8'h01 : 8'h00) | (rx[1] ? 8'h02 : 8'h00) | (rx[2] ? 8'h20 : 8'h00);
      ex[15] = (adf ? 8'h01 : 8'h00) | (tpf ? 8'h02 : 8'h00) | (wat ? 8'h00 : 8'h60);
      for (i = 0; i < 8; i++) ex[16+i] = adf ? vad[63-8*i -: 8] : 8'hff;
      {ex[24], ex[25]} = tpf ? vt : 16'hffff;
      s = 8'h00;
      for (i = 3; i < 26; i++) s = s + ex[i];
      ex[26] = 8'hff - s;
      n0 = nfrm;
      offer();
      @(posedge clk_sys);
      chk(sample_ready, 0, "busy ready");
      for (i = 0; i < 400 && nfrm == n0; i++) @(posedge clk_sys);
      chk(nfrm, n0 + 1, "frame count");
      for (i = 0; i < 27; i++) chk(frm[i], ex[i], "frame byte");
      chk(cks_ok, 1, "host checksum");
      $display("frame test %0d done", k);
   endtask

   task automatic reg_test();
      int n0;
      wb_io(1'b0, SRF_REG_CTRL, 32'h0);
      chk(rd, 32'h0, "ctrl reset");
      wb_io(1'b1, SRF_REG_CTRL, 32'h0000_0001);
      wb_io(1'b0, SRF_REG_CTRL, 32'h0);
      chk(rd[7:0], 8'h01, "ctrl readback");
      n0 = nfrm;
      offer();
      repeat (40) @(posedge clk_sys);
      chk(nfrm, n0, "dropped sample");
      wb_io(1'b0, SRF_REG_STAT, 32'h0);
      chk(rd[15:8], 8'h01, "drop count");
      wb_io(1'b1, 8'h08, 32'hffff_ffff);
      wb_io(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      wb_io(1'b1, SRF_REG_CTRL, 32'h0);
      $display("register test done");
   endtask

   initial begin
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      reg_test();
      run_frame(3'b001, 1'b1, 1'b0, 1'b1, 1'b0, 8'h01);
      run_frame(3'b010, 1'b0, 1'b1, 1'b1, 1'b1, 8'h02);
      run_frame(3'b100, 1'b1, 1'b1, 1'b0, 1'b0, 8'h03);
      run_frame(3'b000, 1'b0, 1'b0, 1'b1, 1'b1, 8'h04);
      wb_io(1'b0, SRF_REG_STAT, 32'h0);
      chk(rd[31:16], 16'h0004, "sent count");
      chk(rd[0], 1'b0, "idle status");
      close_out();
   end
endmodule
`default_nettype wire
